// [rtl/cfg_pkg.sv]
package cfg_pkg;

	// ****************************************************************
	// Widths and framing
	// ****************************************************************
	localparam int DATA_W = 16;
	typedef logic [DATA_W-1:0] word_t;
	typedef logic [17:0] cnt_t;
	localparam logic [3:0] RATIO = 4'h4;
	localparam logic [15:0] IMAGE_WORDS = 16'h0010;
	localparam logic [1:0] FINISH_EDGES = 2'h2;
	localparam logic [3:0] DIV_HALF = 4'h2;

	// ****************************************************************
	// Timing, clk at 50 MHz
	// ****************************************************************
	localparam int CLK_MHZ = 50;
	localparam int POR_CYC = 200;
	localparam int T_CFG_US = 2;
	localparam int CFG_CYC = T_CFG_US * CLK_MHZ;
	localparam int T_STATUS_MIN_US = 268;
	localparam int STATUS_MIN_CYC = T_STATUS_MIN_US * CLK_MHZ;
	localparam int T_ST2CK_US = 2;
	localparam int ST2CK_CYC = T_ST2CK_US * CLK_MHZ;
	localparam int T_CD2UM_MIN_US = 175;
	localparam int CD2UM_MIN_CYC = T_CD2UM_MIN_US * CLK_MHZ;
	localparam int CD2CU_PERIODS = 4;
	localparam int CFG_FMAX_MHZ = 125;
	localparam int CD2CU_CYC =
		(CD2CU_PERIODS * CLK_MHZ + CFG_FMAX_MHZ - 1) / CFG_FMAX_MHZ;
	localparam int USR_INIT_PERIODS = 8576;

	// ****************************************************************
	// State encodings
	// ****************************************************************
	typedef enum logic [6:0] {
		S_POR = 7'h01,
		S_CFGLOW = 7'h02,
		S_STATUS = 7'h04,
		S_LOAD = 7'h08,
		S_INIT = 7'h10,
		S_USER = 7'h20,
		S_ERROR = 7'h40
	} devState_t;

	typedef enum logic [6:0] {
		H_IDLE = 7'h01,
		H_REQ = 7'h02,
		H_WAIT = 7'h04,
		H_GAP = 7'h08,
		H_LOAD = 7'h10,
		H_FIN = 7'h20,
		H_DONE = 7'h40
	} hostState_t;

endpackage

// [rtl/cfg_link_if.sv]
`timescale 1ns/100ps
interface cfg_link_if;
	logic configStartReqN;
	logic handshakeStatusN;
	logic loadComplete;
	logic initDone;
	logic cfgClock;
	cfg_pkg::word_t data;

	modport dev (
		input configStartReqN,
		input cfgClock,
		input data,
		output handshakeStatusN,
		output loadComplete,
		output initDone
	);

	modport host (
		output configStartReqN,
		output cfgClock,
		output data,
		input handshakeStatusN,
		input loadComplete,
		input initDone
	);
endinterface

// [rtl/cfg_loader_dev.sv]
`timescale 1ns/100ps
// Summary of operation
// - Lines idle high; low request restarts.
// - Handshake held low through power-on delay.
// - Load-complete low until image fully loaded.
// - Request low drops both flags quickly.
// - Host holds request low two microseconds.
// - Handshake low pulse within documented bounds.
// - Host waits after handshake before clocking.
// - Each word held for N clocks.
// - Paused clock restarts with data ready.
// - Load-complete rises only on clean image.
// - Two falling edges let initialization pass to user mode.
// - Init-complete low only during initialization, when enabled.
// - Oscillator init reaches user mode in window.
// - User clock init counts its periods.
// - Multi-cycle words whenever ratio exceeds one.
// - Clock held steady, ignored after load.
// - Host drives the low data lines.
module cfg_loader_dev #(
	parameter int PorCyc = cfg_pkg::POR_CYC,
	parameter int StatusMinCyc = cfg_pkg::STATUS_MIN_CYC,
	parameter int Cd2umMinCyc = cfg_pkg::CD2UM_MIN_CYC,
	parameter int UsrInitPeriods = cfg_pkg::USR_INIT_PERIODS
) (
	// System
	input wire logic clk,
	input wire logic nrst,
	// Link
	cfg_link_if.dev link,
	// Options and status
	input wire logic initDoneOptEn,
	input wire logic userClkSel,
	input wire logic userInitClock,
	output logic userMode,
	output logic loadError
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	cfg_pkg::devState_t state_r;
	cfg_pkg::cnt_t cnt_r;
	cfg_pkg::cnt_t ucCnt_r;
	logic reqSync1_r, reqSync2_r;
	logic okSync1_r, okSync2_r;
	logic badSync1_r, badSync2_r;
	logic goSync1_r, goSync2_r;
	logic ucSync1_r, ucSync2_r, ucSync3_r;
	logic idoSync1_r, idoSync2_r, selSync1_r, selSync2_r;
	logic optInit_r, optUser_r;
	logic statusN_r, loadComplete_r, initDone_r;
	logic userMode_r, loadError_r, cfgRunN_r;
	logic [3:0] ratioCnt_r;
	logic [15:0] wordCnt_r;
	cfg_pkg::word_t xor_r;
	logic loadOk_r, loadBad_r;
	logic [1:0] fallCnt_r;
	logic goLvl_r;
	logic ucEdge;
	logic initReady;

	assign ucEdge = ucSync2_r & ~ucSync3_r;

	// ****************************************************************
	// Synchronisers into clk
	// ****************************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reqSync1_r <= 1'b1;
			reqSync2_r <= 1'b1;
			okSync1_r <= 1'b0;
			okSync2_r <= 1'b0;
			badSync1_r <= 1'b0;
			badSync2_r <= 1'b0;
			goSync1_r <= 1'b0;
			goSync2_r <= 1'b0;
			ucSync1_r <= 1'b0;
			ucSync2_r <= 1'b0;
			ucSync3_r <= 1'b0;
			idoSync1_r <= 1'b0;
			idoSync2_r <= 1'b0;
			selSync1_r <= 1'b0;
			selSync2_r <= 1'b0;
		end else begin
			reqSync1_r <= link.configStartReqN;
			reqSync2_r <= reqSync1_r;
			okSync1_r <= loadOk_r;
			okSync2_r <= okSync1_r;
			badSync1_r <= loadBad_r;
			badSync2_r <= badSync1_r;
			goSync1_r <= goLvl_r;
			goSync2_r <= goSync1_r;
			ucSync1_r <= userInitClock;
			ucSync2_r <= ucSync1_r;
			ucSync3_r <= ucSync2_r;
			idoSync1_r <= initDoneOptEn;
			idoSync2_r <= idoSync1_r;
			selSync1_r <= userClkSel;
			selSync2_r <= selSync1_r;
		end
	end

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	// The user clock count starts only after the enable delay.
	always_comb begin
		if (optUser_r) begin
			initReady = ucCnt_r == cfg_pkg::cnt_t'(UsrInitPeriods);
		end else begin
			initReady = cnt_r >= cfg_pkg::cnt_t'(Cd2umMinCyc - 1);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= cfg_pkg::S_POR;
			cnt_r <= '0;
		end else if (!reqSync2_r && state_r != cfg_pkg::S_CFGLOW) begin
			state_r <= cfg_pkg::S_CFGLOW;
			cnt_r <= '0;
		end else begin
			case (state_r)
			cfg_pkg::S_POR: begin
				if (cnt_r == cfg_pkg::cnt_t'(PorCyc - 1)) begin
					state_r <= cfg_pkg::S_LOAD;
					cnt_r <= '0;
				end else begin
					cnt_r <= cnt_r + 1'b1;
				end
			end
			cfg_pkg::S_CFGLOW: begin
				if (reqSync2_r) begin
					state_r <= cfg_pkg::S_STATUS;
				end
			end
			cfg_pkg::S_STATUS: begin
				if (cnt_r == cfg_pkg::cnt_t'(StatusMinCyc - 1)) begin
					state_r <= cfg_pkg::S_LOAD;
					cnt_r <= '0;
				end else begin
					cnt_r <= cnt_r + 1'b1;
				end
			end
			cfg_pkg::S_LOAD: begin
				if (badSync2_r) begin
					state_r <= cfg_pkg::S_ERROR;
				end else if (okSync2_r) begin
					state_r <= cfg_pkg::S_INIT;
					cnt_r <= '0;
				end
			end
			cfg_pkg::S_INIT: begin
				if (initReady && goSync2_r) begin
					state_r <= cfg_pkg::S_USER;
				end else if (initReady) begin
					state_r <= cfg_pkg::S_INIT;
				end else begin
					cnt_r <= cnt_r + 1'b1;
				end
			end
			default: begin
				state_r <= state_r;
			end
			endcase
		end
	end

	// ****************************************************************
	// Initialization clock and options
	// ****************************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ucCnt_r <= '0;
		end else if (state_r != cfg_pkg::S_INIT) begin
			ucCnt_r <= '0;
		end else if (cnt_r >= cfg_pkg::cnt_t'(cfg_pkg::CD2CU_CYC) &&
			ucEdge && !initReady) begin
			ucCnt_r <= ucCnt_r + 1'b1;
		end
	end

	// Options are taken as the image completes, as if loaded with it.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			optInit_r <= 1'b0;
			optUser_r <= 1'b0;
		end else if (state_r == cfg_pkg::S_LOAD && okSync2_r) begin
			optInit_r <= idoSync2_r;
			optUser_r <= selSync2_r;
		end
	end

	// ****************************************************************
	// Pin and status outputs
	// ****************************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			statusN_r <= 1'b0;
			loadComplete_r <= 1'b0;
			initDone_r <= 1'b1;
			userMode_r <= 1'b0;
			loadError_r <= 1'b0;
			cfgRunN_r <= 1'b0;
		end else begin
			statusN_r <= state_r == cfg_pkg::S_LOAD ||
				state_r == cfg_pkg::S_INIT ||
				state_r == cfg_pkg::S_USER;
			loadComplete_r <= state_r == cfg_pkg::S_INIT ||
				state_r == cfg_pkg::S_USER;
			initDone_r <= !(optInit_r && state_r == cfg_pkg::S_INIT);
			userMode_r <= state_r == cfg_pkg::S_USER;
			loadError_r <= state_r == cfg_pkg::S_ERROR;
			cfgRunN_r <= state_r == cfg_pkg::S_LOAD ||
				state_r == cfg_pkg::S_INIT ||
				state_r == cfg_pkg::S_USER;
		end
	end

	assign link.handshakeStatusN = statusN_r;
	assign link.loadComplete = loadComplete_r;
	assign link.initDone = initDone_r;
	assign userMode = userMode_r;
	assign loadError = loadError_r;

	// ****************************************************************
	// Link domain capture
	// ****************************************************************
	// The link logic is held in reset outside load, initialization and user
	// mode, since the clock may stand still and a synchroniser would miss its first edges.
	always_ff @(posedge link.cfgClock or negedge cfgRunN_r) begin
		if (!cfgRunN_r) begin
			ratioCnt_r <= '0;
			wordCnt_r <= '0;
			xor_r <= '0;
			loadOk_r <= 1'b0;
			loadBad_r <= 1'b0;
		end else if (wordCnt_r != cfg_pkg::IMAGE_WORDS) begin
			if (ratioCnt_r == cfg_pkg::RATIO - 4'h1) begin
				ratioCnt_r <= '0;
			end else begin
				ratioCnt_r <= ratioCnt_r + 4'h1;
			end
			if (ratioCnt_r == 4'h0) begin
				xor_r <= xor_r ^ link.data;
				wordCnt_r <= wordCnt_r + 16'h0001;
				if (wordCnt_r == cfg_pkg::IMAGE_WORDS - 16'h0001) begin
					loadOk_r <= (xor_r ^ link.data) == '0;
					loadBad_r <= (xor_r ^ link.data) != '0;
				end
			end
		end
	end

	always_ff @(negedge link.cfgClock or negedge cfgRunN_r) begin
		if (!cfgRunN_r) begin
			fallCnt_r <= '0;
			goLvl_r <= 1'b0;
		end else if (loadOk_r && !goLvl_r) begin
			fallCnt_r <= fallCnt_r + 2'h1;
			goLvl_r <= fallCnt_r == cfg_pkg::FINISH_EDGES - 2'h1;
		end
	end

endmodule

// [rtl/cfg_loader_host.sv]
`timescale 1ns/100ps
module cfg_loader_host (
	// System
	input wire logic clk,
	input wire logic nrst,
	// Link
	cfg_link_if.host link,
	// Image stream
	input wire logic startCfg,
	input wire cfg_pkg::word_t wrData,
	input wire logic wrValid,
	output logic wrReady,
	// Result
	output logic cfgDone,
	output logic cfgFail
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	cfg_pkg::hostState_t state_r;
	cfg_pkg::cnt_t cnt_r;
	cfg_pkg::word_t buf_r [2];
	cfg_pkg::word_t dataOut_r;
	logic wrPtr_r, rdPtr_r;
	logic [1:0] fill_r, fillNxt;
	logic wrReady_r, push, pop, bufValid;
	logic stSync1_r, stSync2_r, lcSync1_r, lcSync2_r;
	logic reqN_r, cfgClk_r, pending_r, cfgDone_r, cfgFail_r;
	logic [3:0] divCnt_r, ratioCnt_r;
	logic [15:0] sent_r;
	logic [1:0] fallCnt_r;
	logic tick, riseEv, fallEv, needWord;

	assign bufValid = fill_r != 2'h0;
	assign push = wrValid && wrReady_r;
	assign tick = divCnt_r == cfg_pkg::DIV_HALF - 4'h1;
	assign riseEv = tick && !cfgClk_r;
	assign fallEv = tick && cfgClk_r;
	assign needWord = sent_r != cfg_pkg::IMAGE_WORDS;
	assign fillNxt = fill_r + {1'b0, push} - {1'b0, pop};

	// Words change only on a falling edge or while the clock is held
	// low, never beside a rising edge.
	always_comb begin
		pop = 1'b0;
		if (state_r == cfg_pkg::H_GAP) begin
			pop = bufValid && cnt_r >= cfg_pkg::cnt_t'(cfg_pkg::ST2CK_CYC - 1);
		end else if (state_r == cfg_pkg::H_LOAD && bufValid && needWord) begin
			pop = (fallEv && ratioCnt_r == 4'h0) || (riseEv && pending_r);
		end
	end

	// ****************************************************************
	// Two-entry buffer
	// ****************************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wrPtr_r <= 1'b0;
			rdPtr_r <= 1'b0;
			fill_r <= 2'h0;
			wrReady_r <= 1'b0;
		end else begin
			if (push) begin
				wrPtr_r <= ~wrPtr_r;
			end
			if (pop) begin
				rdPtr_r <= ~rdPtr_r;
			end
			fill_r <= fillNxt;
			wrReady_r <= fillNxt != 2'h2;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			buf_r[wrPtr_r] <= wrData;
		end
	end

	// ****************************************************************
	// Synchronisers
	// ****************************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stSync1_r <= 1'b0;
			stSync2_r <= 1'b0;
			lcSync1_r <= 1'b0;
			lcSync2_r <= 1'b0;
		end else begin
			stSync1_r <= link.handshakeStatusN;
			stSync2_r <= stSync1_r;
			lcSync1_r <= link.loadComplete;
			lcSync2_r <= lcSync1_r;
		end
	end

	// ****************************************************************
	// Sequencer and clock divider
	// ****************************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= cfg_pkg::H_IDLE;
			cnt_r <= '0;
			reqN_r <= 1'b1;
			cfgClk_r <= 1'b0;
			divCnt_r <= '0;
			ratioCnt_r <= '0;
			pending_r <= 1'b0;
			sent_r <= '0;
			fallCnt_r <= '0;
			dataOut_r <= '0;
			cfgDone_r <= 1'b0;
			cfgFail_r <= 1'b0;
		end else begin
			divCnt_r <= tick ? 4'h0 : divCnt_r + 4'h1;
			if (pop) begin
				dataOut_r <= buf_r[rdPtr_r];
				sent_r <= sent_r + 16'h0001;
			end
			case (state_r)
			cfg_pkg::H_IDLE, cfg_pkg::H_DONE: begin
				cfgClk_r <= 1'b0;
				if (startCfg) begin
					state_r <= cfg_pkg::H_REQ;
					reqN_r <= 1'b0;
					cnt_r <= '0;
					cfgDone_r <= 1'b0;
					cfgFail_r <= 1'b0;
				end
			end
			cfg_pkg::H_REQ: begin
				cnt_r <= cnt_r + 1'b1;
				if (cnt_r == cfg_pkg::cnt_t'(cfg_pkg::CFG_CYC - 1)) begin
					reqN_r <= 1'b1;
					state_r <= cfg_pkg::H_WAIT;
				end
			end
			cfg_pkg::H_WAIT: begin
				cnt_r <= '0;
				sent_r <= '0;
				if (stSync2_r) begin
					state_r <= cfg_pkg::H_GAP;
				end
			end
			cfg_pkg::H_GAP: begin
				if (!cnt_r[17]) begin
					cnt_r <= cnt_r + 1'b1;
				end
				ratioCnt_r <= '0;
				pending_r <= 1'b0;
				if (pop) begin
					state_r <= cfg_pkg::H_LOAD;
					divCnt_r <= '0;
				end
			end
			cfg_pkg::H_LOAD: begin
				if (!stSync2_r) begin
					state_r <= cfg_pkg::H_IDLE;
					cfgFail_r <= 1'b1;
				end else if (lcSync2_r) begin
					state_r <= cfg_pkg::H_FIN;
					fallCnt_r <= '0;
				end
				if (riseEv && pending_r) begin
					pending_r <= !bufValid;
				end else if (riseEv) begin
					cfgClk_r <= 1'b1;
					if (ratioCnt_r == cfg_pkg::RATIO - 4'h1) begin
						ratioCnt_r <= '0;
					end else begin
						ratioCnt_r <= ratioCnt_r + 4'h1;
					end
				end else if (fallEv) begin
					cfgClk_r <= 1'b0;
					pending_r <= ratioCnt_r == 4'h0 && needWord && !bufValid;
				end
			end
			cfg_pkg::H_FIN: begin
				if (riseEv) begin
					cfgClk_r <= 1'b1;
				end else if (fallEv) begin
					cfgClk_r <= 1'b0;
					fallCnt_r <= fallCnt_r + 2'h1;
					if (fallCnt_r == cfg_pkg::FINISH_EDGES - 2'h1) begin
						state_r <= cfg_pkg::H_DONE;
						cfgDone_r <= 1'b1;
					end
				end
			end
			default: begin
				state_r <= cfg_pkg::H_IDLE;
			end
			endcase
		end
	end

	assign link.configStartReqN = reqN_r;
	assign link.cfgClock = cfgClk_r;
	assign link.data = dataOut_r;
	assign wrReady = wrReady_r;
	assign cfgDone = cfgDone_r;
	assign cfgFail = cfgFail_r;

endmodule

// [dv/cfg_link_chk.sv]
`timescale 1ns/100ps
module cfg_link_chk #(
	parameter int PorCyc = cfg_pkg::POR_CYC,
	parameter int StatusMinCyc = cfg_pkg::STATUS_MIN_CYC
) (
	// System
	input wire logic clk,
	input wire logic nrst,
	// Link
	input wire logic configStartReqN,
	input wire logic handshakeStatusN,
	input wire logic loadComplete,
	input wire logic initDone,
	input wire logic cfgClock,
	input wire cfg_pkg::word_t data
);
	// ********************************
	// Cycle counters
	// ********************************
	// upCnt_r, hiCnt_r and stCnt_r saturate so that a long user-mode stay cannot wrap them.
	localparam int SAT = 1000000;
	localparam int LAST_RISE =
		int'(cfg_pkg::RATIO) * (int'(cfg_pkg::IMAGE_WORDS) - 1);
	int upCnt_r, hiCnt_r, loCnt_r, stCnt_r, riseCnt_r;
	logic restarted_r;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			upCnt_r <= 0;
			restarted_r <= 1'h0;
		end else begin
			if (upCnt_r < SAT) upCnt_r <= upCnt_r + 1;
			if (!configStartReqN) restarted_r <= 1'h1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hiCnt_r <= 0;
			loCnt_r <= 0;
		end else if (configStartReqN) begin
			loCnt_r <= 0;
			if (hiCnt_r < SAT) hiCnt_r <= hiCnt_r + 1;
		end else begin
			hiCnt_r <= 0;
			loCnt_r <= loCnt_r + 1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stCnt_r <= 0;
			riseCnt_r <= 0;
		end else if (!handshakeStatusN) begin
			stCnt_r <= 0;
			riseCnt_r <= 0;
		end else begin
			if (stCnt_r < SAT) stCnt_r <= stCnt_r + 1;
			if ($rose(cfgClock)) riseCnt_r <= riseCnt_r + 1;
		end
	end

	// ********************************
	// Properties
	// ********************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence fallEdge;
		$fell(cfgClock);
	endsequence
	sequence flagsLow;
		!handshakeStatusN && !loadComplete;
	endsequence

	chk_flags_drop: assert property (
		$fell(configStartReqN) |-> ##[1:30] flagsLow)
		else $error("flags late after request");
	chk_por_hold: assert property (
		!restarted_r && upCnt_r < PorCyc |-> !handshakeStatusN)
		else $error("status released during power-on delay");
	chk_status_min: assert property (
		$rose(handshakeStatusN) && restarted_r |-> hiCnt_r >= StatusMinCyc)
		else $error("status pulse too short");
	chk_status_max: assert property (
		restarted_r && hiCnt_r == StatusMinCyc + 10 |-> handshakeStatusN)
		else $error("status released late");
	chk_req_width: assert property (
		$rose(configStartReqN) |-> loCnt_r >= cfg_pkg::CFG_CYC - 1)
		else $error("request pulse too short");
	chk_flag_low: assert property (
		!handshakeStatusN |-> !loadComplete)
		else $error("load flag high while status low");
	chk_load_count: assert property (
		$rose(loadComplete) |-> riseCnt_r > LAST_RISE)
		else $error("load flag before whole image");
	chk_load_soon: assert property (
		$rose(cfgClock) && riseCnt_r == LAST_RISE |->
		##[1:12] (loadComplete || !handshakeStatusN))
		else $error("no verdict after last word");
	chk_word_hold: assert property (
		$changed(data) && handshakeStatusN && !loadComplete |->
		!cfgClock && riseCnt_r % int'(cfg_pkg::RATIO) == 0)
		else $error("word changed inside its hold");
	chk_first_gap: assert property (
		$rose(cfgClock) && riseCnt_r == 0 |-> stCnt_r >= cfg_pkg::ST2CK_CYC)
		else $error("first clock edge too soon");
	chk_finish_edges: assert property (
		$rose(loadComplete) |-> ##[1:40] fallEdge ##[1:8] fallEdge)
		else $error("finishing falling edges missing");
	chk_init_rise: assert property (
		$rose(initDone) |-> loadComplete && handshakeStatusN)
		else $error("init done before load complete");
endmodule

// [dv/parallel_config_load_multi_cycle_bench.sv]
`timescale 1ns/100ps
module parallel_config_load_multi_cycle_bench;
	// ********************************
	// Clocks, reset and instances
	// ********************************
	localparam int POR_T = 20;
	localparam int STAT_T = 200;
	localparam int INIT_T = 100;
	localparam int USR_T = 20;
	logic clk, nrst, userInitClock, initDoneOptEn, userClkSel;
	logic startCfg, wrValid, wrReady, cfgDone, cfgFail, userMode, loadError;
	logic reqN, statN, ldDone, iDone;
	cfg_pkg::word_t wrData;
	cfg_pkg::word_t img[16];
	int n_errors = 0;
	int n_compared = 0;
	int cyc = 0;

	cfg_link_if cfg_link_if_inst ();
	assign reqN = cfg_link_if_inst.configStartReqN;
	assign statN = cfg_link_if_inst.handshakeStatusN;
	assign ldDone = cfg_link_if_inst.loadComplete;
	assign iDone = cfg_link_if_inst.initDone;

	cfg_loader_dev #(.PorCyc(POR_T), .StatusMinCyc(STAT_T),
		.Cd2umMinCyc(INIT_T), .UsrInitPeriods(USR_T)) cfg_loader_dev_inst (
		.clk(clk), .nrst(nrst), .link(cfg_link_if_inst.dev),
		.initDoneOptEn(initDoneOptEn), .userClkSel(userClkSel),
		.userInitClock(userInitClock), .userMode(userMode),
		.loadError(loadError));
	cfg_loader_host cfg_loader_host_inst (
		.clk(clk), .nrst(nrst), .link(cfg_link_if_inst.host),
		.startCfg(startCfg), .wrData(wrData), .wrValid(wrValid),
		.wrReady(wrReady), .cfgDone(cfgDone), .cfgFail(cfgFail));
	cfg_link_chk #(.PorCyc(POR_T), .StatusMinCyc(STAT_T)) cfg_link_chk_inst (
		.clk(clk), .nrst(nrst), .configStartReqN(reqN),
		.handshakeStatusN(statN), .loadComplete(ldDone), .initDone(iDone),
		.cfgClock(cfg_link_if_inst.cfgClock), .data(cfg_link_if_inst.data));

	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	// The user clock is offset so that it never lines up with clk.
	initial begin
		userInitClock = 1'h0;
		#7;
		forever #32 userInitClock = ~userInitClock;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_errors++;
			end_sim();
		end
	end

	// ********************************
	// Shared tasks
	// ********************************
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask
	task automatic waitSig(ref logic s, input logic v, input int lim,
		output int k);
		k = 0;
		while (s !== v && k < lim) begin
			@(negedge clk);
			k++;
		end
	endtask
	// Valid stays up on return so that back-to-back words need no gap.
	task automatic push(input cfg_pkg::word_t w);
		int k;
		wrData = w;
		wrValid = 1'h1;
		waitSig(wrReady, 1'h1, 2000, k);
		@(negedge clk);
	endtask
	task automatic end_sim();
		$display("Compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ********************************
	// Scenarios
	// ********************************
	task automatic power_up();
		int k;
		repeat (POR_T - 4) @(negedge clk);
		chk("por status", 1'h0, statN);
		chk("por load flag", 1'h0, ldDone);
		waitSig(statN, 1'h1, 200, k);
		chk("por release", 1, statN === 1'h1 && k + POR_T - 4 >= POR_T);
	endtask
	task automatic config_run(input logic opt, input logic sel,
		input logic bad);
		int k;
		int t;
		cfg_pkg::word_t acc;
		initDoneOptEn = opt;
		userClkSel = sel;
		acc = 16'h0000;
		for (int i = 0; i < 15; i++) begin
			img[i] = 16'h1357 * 16'(i + 1);
			acc = acc ^ img[i];
		end
		img[15] = bad ? ~acc : acc;
		push(img[0]);
		push(img[1]);
		wrValid = 1'h0;
		repeat (3) @(negedge clk);
		chk("buffer full", 1'h0, wrReady);
		startCfg = 1'h1;
		@(negedge clk);
		startCfg = 1'h0;
		waitSig(reqN, 1'h0, 20, k);
		waitSig(statN, 1'h0, 40, t);
		chk("flags low delay", 1, t <= 30 && ldDone === 1'h0);
		waitSig(statN, 1'h1, 2000, k);
		chk("error cleared", 1'h0, loadError);
		for (int i = 2; i < 16; i++) begin
			if (i == 9) begin
				wrValid = 1'h0;
				repeat (40) @(negedge clk);
				chk("paused clock", 1'h0, cfg_link_if_inst.cfgClock);
				chk("flag low in load", 1'h0, ldDone);
			end
			push(img[i]);
		end
		wrValid = 1'h0;
		if (bad) begin
			waitSig(cfgFail, 1'h1, 400, k);
			chk("host fail", 1'h1, cfgFail);
			chk("load error", 1'h1, loadError);
			chk("bad flags", 3'h0, {ldDone, statN, userMode});
		end else begin
			waitSig(ldDone, 1'h1, 400, k);
			repeat (2) @(negedge clk);
			chk("init low", !opt, iDone);
			waitSig(userMode, 1'h1, 22000, t);
			// The first counted user clock edge may come right after enable.
			chk("init min", 1, t + 2 >= (sel ? USR_T * 64 / 20 - 4 : INIT_T - 1));
			chk("init max", 1, t + 2 <= 21850);
			chk("host done", 1'h1, cfgDone);
			chk("host fail clear", 1'h0, cfgFail);
			chk("idle lines", 4'hF, {reqN, statN, ldDone, iDone});
		end
	endtask

	initial begin
		nrst = 1'h0;
		startCfg = 1'h0;
		wrValid = 1'h0;
		wrData = 16'h0000;
		initDoneOptEn = 1'h0;
		userClkSel = 1'h0;
		repeat (10) @(negedge clk);
		nrst = 1'h1;
		power_up();
		config_run(1'h1, 1'h0, 1'h0);
		config_run(1'h0, 1'h0, 1'h1);
		config_run(1'h0, 1'h1, 1'h0);
		end_sim();
	end
endmodule
